// File: logic/plp_pkg.sv
// package for the loop parameter core: register map, field layout, limits
// assumes a 32-bit apb master and fixed-point settings in integer steps
package plp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_GAIN     = 8'h04;
  localparam logic [7:0] OFS_INTEG    = 8'h08;
  localparam logic [7:0] OFS_DERIV    = 8'h0C;
  localparam logic [7:0] OFS_MANUAL   = 8'h10;
  localparam logic [7:0] OFS_SETPT    = 8'h14;
  localparam logic [7:0] OFS_SETPT_EF = 8'h18;
  localparam logic [7:0] OFS_CRV_LIM  = 8'h1C;
  localparam logic [7:0] OFS_SNS_MIN  = 8'h20;
  localparam logic [7:0] OFS_SNS_MAX  = 8'h24;
  localparam logic [7:0] OFS_TMP_LIM  = 8'h28;
  localparam logic [7:0] OFS_RAMP     = 8'h2C;
  localparam logic [7:0] OFS_TIMES    = 8'h30;
  localparam logic [7:0] OFS_STATUS   = 8'h34;
  // control field positions
  localparam int CTL_MODE_LO = 0;
  localparam int CTL_MODE_HI = 1;
  localparam int CTL_SENSOR  = 2;
  localparam int CTL_RAMP    = 3;
  localparam int CTL_TLIM    = 4;
  // status field positions
  localparam int ST_TRIP  = 0;
  localparam int ST_RAMP  = 1;
  localparam int ST_CONV  = 2;
  localparam int ST_INTEG = 3;
  // setting limits and defaults, tenths for gain and integral
  localparam logic [15:0] GAIN_MAX  = 16'h2710; // 1000.0
  localparam logic [15:0] GAIN_DEF  = 16'h01F4; // 50.0
  localparam logic [15:0] INTEG_MAX = 16'h2710; // 1000.0
  localparam logic [15:0] INTEG_DEF = 16'h00C8; // 20.0
  localparam logic [15:0] DERIV_MAX = 16'h00C8; // 200 %
  localparam logic [15:0] DERIV_DEF = 16'h0000;
  localparam logic [15:0] MAN_MAX   = 16'h2710; // 100.00 %
  localparam logic [15:0] MAN_DEF   = 16'h0000;
  localparam logic [15:0] FULL_SCL  = 16'h2710; // 100.00 %
  // time constants in tenths of a second: 1000 s divided by the setting
  localparam logic [31:0] INTEG_NUM = 32'h000186A0; // 100000
  localparam logic [31:0] DERIV_DEN = 32'h00000190; // 100 % times 4
  localparam logic [31:0] ZERO32    = 32'h00000000;
  // output modes
  typedef enum logic [1:0] {
    PLP_OFF    = 2'h0,
    PLP_CLOSED = 2'h1,
    PLP_OPEN   = 2'h2
  } plp_mode_t;
  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } plp_apb_req_t;
  // apb answer bundle
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } plp_apb_rsp_t;
endpackage

// File: logic/plp_core.sv
// top of the loop parameter core: apb registers, pid output combining, setpoint
// assumes a synchronous apb master, pid result and readings on ref_clk
//
// Function
// (R1) gain 0..1000 step 0.1, default 50
// (R2) integral 0..1000 step 0.1, default 20
// (R3) integral zero disables reset term
// (R4) integral setting is 1000 over seconds
// (R5) derivative 0..200 percent of quarter integral
// (R6) host keeps gain above zero closed-loop
// (R7) open loop drives manual output only
// (R8) closed loop adds manual to pid
// (R9) manual 0..100 percent step 0.01
// (R10) setpoint in temperature or sensor units
// (R11) host assigns control input before setpoint
// (R12) ramping only in temperature units
// (R13) setpoint clamped by curve or sensor
// (R14) setpoint limit acts on entry only
// (R15) reading over limit switches heaters off
// (R16) sensor setpoint has reading resolution
// (R17) unit change converts setpoint via curve
// (R18) output saturated to 0..100 percent
// (R19) ramp moves setpoint at rate either way
`timescale 1ns/1ns
`default_nettype none
module plp_core #(
  parameter int SP_W = 24
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // register bus
  input  wire plp_pkg::plp_apb_req_t apb_req,
  output var  plp_pkg::plp_apb_rsp_t apb_rsp,
  // loop inputs
  input  wire logic signed [16:0]   pid_result,
  input  wire logic [SP_W-1:0]      reading,
  input  wire logic                 ramp_tick,
  // curve conversion port
  input  wire logic                 conv_ack,
  input  wire logic [SP_W-1:0]      conv_result,
  output logic                      conv_req,
  output logic                      conv_to_sensor,
  output logic [SP_W-1:0]           conv_value,
  // loop outputs
  output logic [15:0]               heater_out,
  output logic                      heater_off,
  output logic [15:0]               gain,
  output logic                      integ_on,
  output logic [31:0]               integ_time,
  output logic [31:0]               deriv_time,
  output logic [SP_W-1:0]           setpoint_eff
);
  import plp_pkg::*;

  // clamp a write value to its maximum
  function automatic logic [15:0] clip(input logic [31:0] v, input logic [15:0] mx);
    clip = (v > {16'h0000, mx}) ? mx : v[15:0];
  endfunction

  // clamp a setpoint between two bounds
  function automatic logic [SP_W-1:0] bound(input logic [SP_W-1:0] v,
                                            input logic [SP_W-1:0] lo,
                                            input logic [SP_W-1:0] hi);
    bound = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  logic [1:0]      mode;
  logic            sensor_units;
  logic            ramp_en;
  logic            tlim_en;
  logic [15:0]     integ;
  logic [15:0]     deriv;
  logic [15:0]     manual;
  logic [SP_W-1:0] target;
  logic [SP_W-1:0] crv_lim;
  logic [SP_W-1:0] sns_min;
  logic [SP_W-1:0] sns_max;
  logic [SP_W-1:0] tmp_lim;
  logic [SP_W-1:0] ramp_step;
  logic            trip;
  logic            conv_busy;

  // bus decode
  logic acc;
  logic wr;
  logic known;
  logic [SP_W-1:0] wsp;
  assign acc = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign wr  = acc & apb_req.pwrite;
  assign wsp = apb_req.pwdata[SP_W-1:0];

  // address map check
  always_comb begin
    unique case (apb_req.paddr)
      OFS_CTRL, OFS_GAIN, OFS_INTEG, OFS_DERIV, OFS_MANUAL, OFS_SETPT,
      OFS_SETPT_EF, OFS_CRV_LIM, OFS_SNS_MIN, OFS_SNS_MAX, OFS_TMP_LIM,
      OFS_RAMP, OFS_TIMES, OFS_STATUS: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // read mux
  logic [31:0] rd;
  always_comb begin
    rd = ZERO32;
    unique case (apb_req.paddr)
      OFS_CTRL: begin
        rd[CTL_MODE_HI:CTL_MODE_LO] = mode;
        rd[CTL_SENSOR] = sensor_units;
        rd[CTL_RAMP]   = ramp_en;
        rd[CTL_TLIM]   = tlim_en;
      end
      OFS_GAIN:     rd[15:0] = gain;
      OFS_INTEG:    rd[15:0] = integ;
      OFS_DERIV:    rd[15:0] = deriv;
      OFS_MANUAL:   rd[15:0] = manual;
      OFS_SETPT:    rd[SP_W-1:0] = target;
      OFS_SETPT_EF: rd[SP_W-1:0] = setpoint_eff;
      OFS_CRV_LIM:  rd[SP_W-1:0] = crv_lim;
      OFS_SNS_MIN:  rd[SP_W-1:0] = sns_min;
      OFS_SNS_MAX:  rd[SP_W-1:0] = sns_max;
      OFS_TMP_LIM:  rd[SP_W-1:0] = tmp_lim;
      OFS_RAMP:     rd[SP_W-1:0] = ramp_step;
      OFS_TIMES:    rd = integ_time;
      OFS_STATUS: begin
        rd[ST_TRIP]  = trip;
        rd[ST_RAMP]  = setpoint_eff != target;
        rd[ST_CONV]  = conv_busy;
        rd[ST_INTEG] = integ_on;
      end
      default:      rd = ZERO32;
    endcase
  end

  // apb answer: ready in the first access cycle, data latched at setup
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= apb_req.psel & ~apb_req.penable;
      if (apb_req.psel & ~apb_req.penable) begin
        apb_rsp.prdata  <= rd;
        apb_rsp.pslverr <= ~known;
      end
    end
  end

  // mode and option bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode    <= PLP_OFF;
      ramp_en <= 1'b0;
      tlim_en <= 1'b0;
    end else if (wr && apb_req.paddr == OFS_CTRL) begin
      mode    <= apb_req.pwdata[CTL_MODE_HI:CTL_MODE_LO];
      ramp_en <= apb_req.pwdata[CTL_RAMP];
      tlim_en <= apb_req.pwdata[CTL_TLIM];
    end
  end

  // pid settings, clamped to their ranges on write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gain   <= GAIN_DEF;   // [R1]
      integ  <= INTEG_DEF;  // [R2]
      deriv  <= DERIV_DEF;  // [R5]
      manual <= MAN_DEF;    // [R9]
    end else if (wr) begin
      if (apb_req.paddr == OFS_GAIN) gain <= clip(apb_req.pwdata, GAIN_MAX); // [R1]
      if (apb_req.paddr == OFS_INTEG) integ <= clip(apb_req.pwdata, INTEG_MAX); // [R2]
      if (apb_req.paddr == OFS_DERIV) deriv <= clip(apb_req.pwdata, DERIV_MAX); // [R5]
      if (apb_req.paddr == OFS_MANUAL) manual <= clip(apb_req.pwdata, MAN_MAX); // [R9]
    end
  end

  // limit registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      crv_lim   <= '1;
      sns_min   <= '0;
      sns_max   <= '1;
      tmp_lim   <= '1;
      ramp_step <= '0;
    end else if (wr) begin
      if (apb_req.paddr == OFS_CRV_LIM) crv_lim <= wsp;
      if (apb_req.paddr == OFS_SNS_MIN) sns_min <= wsp;
      if (apb_req.paddr == OFS_SNS_MAX) sns_max <= wsp;
      if (apb_req.paddr == OFS_TMP_LIM) tmp_lim <= wsp;
      if (apb_req.paddr == OFS_RAMP) ramp_step <= wsp;
    end
  end

  // time constants in tenths of a second
  logic [31:0] next_it;
  logic [31:0] next_dt;
  always_comb begin
    next_it = (integ == '0) ? ZERO32 : INTEG_NUM / {16'h0000, integ}; // [R4]
    next_dt = ({16'h0000, deriv} * next_it) / DERIV_DEN;              // [R5]
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      integ_time <= ZERO32;
      deriv_time <= ZERO32;
      integ_on   <= 1'b0;
    end else begin
      integ_time <= next_it;
      deriv_time <= next_dt;
      integ_on   <= integ != '0; // [R3]
    end
  end

  // setpoint entry clamp, entry path only, reading untouched
  logic [SP_W-1:0] entry;
  assign entry = sensor_units ? bound(wsp, sns_min, sns_max)  // [R13] [R16]
                              : bound(wsp, '0, crv_lim);     // [R13] [R14]

  // units selection and curve conversion handshake
  logic set_wr;
  logic unit_wr;
  assign set_wr  = wr && apb_req.paddr == OFS_SETPT;
  assign unit_wr = wr && apb_req.paddr == OFS_CTRL &&
                   apb_req.pwdata[CTL_SENSOR] != sensor_units;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sensor_units   <= 1'b0;
      conv_busy      <= 1'b0;
      conv_req       <= 1'b0;
      conv_to_sensor <= 1'b0;
      conv_value     <= '0;
    end else if (conv_busy) begin
      if (conv_ack) begin
        conv_busy <= 1'b0;
        conv_req  <= 1'b0;
      end
    end else if (unit_wr) begin
      sensor_units   <= apb_req.pwdata[CTL_SENSOR]; // [R10]
      conv_busy      <= 1'b1;                       // [R17]
      conv_req       <= 1'b1;
      conv_to_sensor <= apb_req.pwdata[CTL_SENSOR];
      conv_value     <= setpoint_eff;
    end
  end

  // target and effective setpoint with ramp
  logic ramping;
  assign ramping = ramp_en & ~sensor_units; // [R12]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      target       <= '0;
      setpoint_eff <= '0;
    end else if (conv_busy && conv_ack) begin
      target       <= conv_result; // [R17]
      setpoint_eff <= conv_result;
    end else if (set_wr) begin
      target <= entry;
      if (!ramping) setpoint_eff <= entry; // [R12]
    end else if (!ramp_en) begin
      target <= setpoint_eff; // ramp switched off: hold current value
    end else if (ramping && ramp_tick && setpoint_eff != target) begin
      if (target > setpoint_eff) begin // [R19]
        setpoint_eff <= (target - setpoint_eff > ramp_step) ?
                        setpoint_eff + ramp_step : target;
      end else begin
        setpoint_eff <= (setpoint_eff - target > ramp_step) ?
                        setpoint_eff - ramp_step : target;
      end
    end
  end

  // over-temperature trip, cleared by writing the control register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trip <= 1'b0;
    end else if (tlim_en && reading > tmp_lim) begin
      trip <= 1'b1; // [R15]
    end else if (wr && apb_req.paddr == OFS_CTRL) begin
      trip <= 1'b0;
    end
  end

  // output combining and saturation
  logic signed [17:0] sum;
  logic [15:0] next_out;
  always_comb begin
    sum = 18'(pid_result) + 18'($signed({2'b00, manual})); // [R8]
    unique case (mode)
      PLP_OPEN: next_out = manual; // [R7]
      PLP_CLOSED: begin
        if (sum < 0) next_out = '0; // [R18]
        else if (sum > $signed({2'b00, FULL_SCL})) next_out = FULL_SCL; // [R18]
        else next_out = sum[15:0];
      end
      default: next_out = '0;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      heater_out <= '0;
      heater_off <= 1'b1;
    end else begin
      heater_out <= trip ? '0 : next_out; // [R15]
      // mode code 3 is not decoded as a drive mode, so it counts as off
      heater_off <= trip || (mode != PLP_OPEN && mode != PLP_CLOSED); // [R15] [R7]
    end
  end
endmodule
`default_nettype wire

// File: verification/plp_core_asserts.sv
// checker for the loop parameter core, bound to every plp_core
// assumes the plp_core ports and the plp_pkg limits
`timescale 1ns/1ns
`default_nettype none
module plp_core_asserts #(
  parameter int SP_W = 24
) (
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst,
  // watched ports
  input wire plp_pkg::plp_apb_req_t apb_req,
  input wire logic                  ramp_tick,
  input wire logic                  conv_ack,
  input wire logic [SP_W-1:0]       conv_result,
  input wire logic                  conv_req,
  input wire logic [SP_W-1:0]       conv_value,
  input wire logic [15:0]           heater_out,
  input wire logic                  heater_off,
  input wire logic [15:0]           gain,
  input wire logic                  integ_on,
  input wire logic [31:0]           integ_time,
  input wire logic [31:0]           deriv_time,
  input wire logic [SP_W-1:0]       setpoint_eff
);
  import plp_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // output level and gain setting stay in range
  property p_sat; heater_out <= FULL_SCL; endproperty
  a_sat: assert property (p_sat) else $error("heater out above full scale");
  property p_gain; gain <= GAIN_MAX; endproperty
  a_gain: assert property (p_gain) else $error("gain above max");
  // derivative never above half the settled integral time
  property p_dt; $stable(integ_time) [*3] |-> deriv_time <= (integ_time >> 1); endproperty
  a_dt: assert property (p_dt) else $error("derivative time too long");
  // zero setting means no integral, else 10 to 100000 tenths
  property p_ion;
    $stable(integ_time) [*2] |-> (integ_on ? (integ_time >= 32'h0000000A
      && integ_time <= INTEG_NUM) : integ_time == ZERO32);
  endproperty
  a_ion: assert property (p_ion) else $error("integral time and enable disagree");
  // a held trip or off state keeps the load dark
  property p_off; heater_off [*3] |-> heater_out == 16'h0000; endproperty
  a_off: assert property (p_off) else $error("heater driven while off");
  // conversion request holds until answered, answer lands at once
  property p_chold; conv_req && !conv_ack |=> conv_req && $stable(conv_value); endproperty
  a_chold: assert property (p_chold) else $error("conversion request dropped");
  property p_cack; conv_req && conv_ack |=> !conv_req && setpoint_eff == $past(conv_result);
  endproperty
  a_cack: assert property (p_cack) else $error("conversion result not taken");
  // effective setpoint moves only on a tick, answer or bus access
  property p_sp;
    !$past(ramp_tick) && !$past(conv_ack) && !$past(apb_req.psel)
      && !$past(apb_req.psel, 2) |-> $stable(setpoint_eff);
  endproperty
  a_sp: assert property (p_sp) else $error("setpoint moved without cause");
endmodule
bind plp_core plp_core_asserts #(.SP_W(SP_W)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .apb_req(apb_req), .ramp_tick(ramp_tick), .conv_ack(conv_ack),
  .conv_result(conv_result), .conv_req(conv_req), .conv_value(conv_value),
  .heater_out(heater_out), .heater_off(heater_off), .gain(gain), .integ_on(integ_on),
  .integ_time(integ_time), .deriv_time(deriv_time), .setpoint_eff(setpoint_eff));
`default_nettype wire

// File: verification/plp_conv_model.sv
// curve conversion partner: answers each request lat+1 cycles after it is raised
// assumes one request at a time, held until acknowledged
`timescale 1ns/1ns
`default_nettype none
module plp_conv_model (
  // clock and reset
  input wire logic         ref_clk,
  input wire logic         rst,
  // request side
  input wire logic         conv_req,
  input wire logic         conv_to_sensor,
  input wire logic [23:0]  conv_value,
  input wire logic [3:0]   lat,
  // answer side
  output logic             conv_ack,
  output logic [23:0]      conv_result
);
  logic [3:0] cnt;
  logic       done;
  // toy curve: sensor value is twice the temperature
  always_ff @(posedge ref_clk) begin
    conv_ack <= 1'b0;
    conv_result <= ~conv_result; // not valid outside the answer
    if (rst) begin
      cnt <= 4'h0;
      done <= 1'b0;
      conv_result <= 24'h5A5A5A;
    end else if (!conv_req) begin
      cnt <= 4'h0;
      done <= 1'b0;
    end else if (!done && cnt == lat) begin
      conv_ack <= 1'b1;
      done <= 1'b1;
      conv_result <= conv_to_sensor ? conv_value << 1 : conv_value >> 1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: verification/plp_core_tb.sv
// self-checking bench for plp_core with the conversion partner
// assumes plp_pkg, plp_conv_model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module plp_core_tb;
  import plp_pkg::*;
  logic               ref_clk, rst, ramp_tick, conv_ack, conv_req, conv_to_sensor;
  logic               heater_off, integ_on, e;
  logic [23:0]        reading, conv_result, conv_value, setpoint_eff;
  logic signed [16:0] pid_result;
  logic [15:0]        heater_out, gain;
  logic [31:0]        integ_time, deriv_time, rd;
  logic [3:0]         lat;
  plp_apb_req_t       req;
  plp_apb_rsp_t       rsp;
  int                 err_total, compares, cyc, seed, se, tg, m, man, p, t;
  int                 iv[4] = '{200, 10000, 1, 0};
  int                 dv[4] = '{100, 200, 50, 100};
  logic [7:0]         ofs[4] = '{OFS_GAIN, OFS_INTEG, OFS_DERIV, OFS_MANUAL};
  logic [15:0]        mx[4] = '{GAIN_MAX, INTEG_MAX, DERIV_MAX, MAN_MAX};
  plp_core #(.SP_W(24)) dut (.ref_clk(ref_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .pid_result(pid_result), .reading(reading), .ramp_tick(ramp_tick),
    .conv_ack(conv_ack), .conv_result(conv_result), .conv_req(conv_req),
    .conv_to_sensor(conv_to_sensor), .conv_value(conv_value), .heater_out(heater_out),
    .heater_off(heater_off), .gain(gain), .integ_on(integ_on), .integ_time(integ_time),
    .deriv_time(deriv_time), .setpoint_eff(setpoint_eff));
  plp_conv_model pm (.ref_clk(ref_clk), .rst(rst), .conv_req(conv_req),
    .conv_to_sensor(conv_to_sensor), .conv_value(conv_value), .lat(lat),
    .conv_ack(conv_ack), .conv_result(conv_result));
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", nm, x, s);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, x);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // ramp ticks with reference step of 100 toward target
  task automatic tchk(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      ramp_tick <= 1'b1;
      @(posedge ref_clk);
      ramp_tick <= 1'b0;
      se = (se < tg) ? ((se + 100 < tg) ? se + 100 : tg) : ((se - 100 > tg) ? se - 100 : tg);
    end
    wt(2);
    chk("ramp", 32'(setpoint_eff), se);
  endtask
  function automatic int hexp(int md, int pd, int mn, bit trip);
    if (trip || md == 0 || md == 3) return 0;
    if (md == 2) return mn;
    return (pd + mn < 0) ? 0 : (pd + mn > 10000) ? 10000 : pd + mn;
  endfunction
  // main sequence
  initial begin
    seed = 763;
    rst = 1'b1;
    req = '0;
    pid_result = '0;
    reading = '0;
    ramp_tick = 1'b0;
    lat = 4'h0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    wt(2);
    chk("gain", 32'(gain), GAIN_DEF);
    chk("itime", integ_time, INTEG_NUM / INTEG_DEF);
    rdchk("integ", OFS_INTEG, INTEG_DEF);
    rdchk("deriv", OFS_DERIV, DERIV_DEF);
    rdchk("manual", OFS_MANUAL, MAN_DEF);
    for (int i = 0; i < 4; i++) begin
      wr(ofs[i], 32'h0000FFFF);
      rdchk("clamp", ofs[i], mx[i]);
      wr(ofs[i], mx[i] - 16'h1);
      rdchk("step", ofs[i], mx[i] - 16'h1);
    end
    $display("test settings done");
    for (int i = 0; i < 4; i++) begin
      wr(OFS_INTEG, iv[i]);
      wr(OFS_DERIV, dv[i]);
      wt(3);
      t = iv[i] ? 100000 / iv[i] : 0;
      chk("itime", integ_time, t);
      chk("dtime", deriv_time, dv[i] * t / 400);
      chk("ion", 32'(integ_on), iv[i] != 0);
    end
    apb(1'b0, 8'h3C, 32'h0);
    chk("slverr", 32'(e), 1);
    wr(OFS_TIMES, 32'h0000ABCD);
    rdchk("times_ro", OFS_TIMES, t);
    $display("test times done");
    for (int i = 0; i < 8; i++) begin
      m = i % 4;
      man = {$random(seed)} % 10001;
      p = $random(seed) % 15000;
      wr(OFS_CTRL, m); // gain stays nonzero for closed loop
      wr(OFS_MANUAL, man);
      pid_result <= 17'(p);
      wt(3);
      chk("heater", 32'(heater_out), hexp(m, p, man, 1'b0));
      chk("hoff", 32'(heater_off), m == 0 || m == 3);
    end
    wr(OFS_TMP_LIM, 32'h64);
    wr(OFS_MANUAL, 32'hBB8);
    wr(OFS_CTRL, 32'h12);
    reading <= 24'hC8;
    wt(4);
    chk("trip", 32'(heater_off), 1);
    chk("trip_out", 32'(heater_out), hexp(2, 0, 3000, 1'b1));
    rdchk("status", OFS_STATUS, 32'h1);
    reading <= 24'h32;
    wr(OFS_CTRL, 32'h12);
    wt(3);
    chk("open", 32'(heater_out), hexp(2, 0, 3000, 1'b0));
    $display("test output done");
    wr(OFS_CTRL, 32'h1); // loop formed before the first setpoint
    wr(OFS_CRV_LIM, 32'h3E8);
    wr(OFS_SETPT, 32'h1388);
    se = 1000;
    tg = 1000;
    wt(2);
    chk("sp_clamp", 32'(setpoint_eff), se);
    rdchk("sp_tgt", OFS_SETPT, tg);
    wr(OFS_RAMP, 32'h64);
    wr(OFS_CTRL, 32'h9);
    wr(OFS_SETPT, 32'h1F4);
    tg = 500;
    tchk(2);
    tchk(4);
    wr(OFS_SETPT, 32'h2BC);
    tg = 700;
    tchk(1);
    tchk(2);
    rdchk("sp_eff", OFS_SETPT_EF, se);
    lat <= 4'h5;
    wr(OFS_CTRL, 32'hD);
    se = se * 2;
    wt(12);
    chk("to_sensor", 32'(setpoint_eff), se);
    wr(OFS_SNS_MIN, 32'h7D0);
    wr(OFS_SNS_MAX, 32'hBB8);
    wr(OFS_SETPT, 32'h2328);
    wt(2);
    chk("sns_max", 32'(setpoint_eff), 32'hBB8);
    wr(OFS_SETPT, 32'h64);
    wt(2);
    chk("sns_min", 32'(setpoint_eff), 32'h7D0);
    lat <= 4'h0;
    wr(OFS_CTRL, 32'h9);
    wt(6);
    chk("to_temp", 32'(setpoint_eff), 32'h7D0 >> 1);
    $display("test setpoint done");
    print_verdict();
  end
endmodule
`default_nettype wire
